// ### logic/sock_evt_pkg.sv
// Shared constants for the socket status event flag block
// Overview of operation
// RULE1 - Event flags record only that a change happened, never the new state.
// RULE2 - The interrupt output comes from latched flags, never from live pin levels.
// RULE3 - Writing one to a flag clears it; writing zero leaves it alone.
// RULE4 - Writing one to a force bit sets the matching flag like a real event.
// RULE5 - Bus reset clears every event flag to all zeros.
// RULE6 - Leaving card reset may set flags again if status still holds.
// RULE7 - Enabled interrupts fire for every set unmasked flag, including older ones.
// RULE8 - Software clears pending flags before it enables interrupts.
// RULE9 - Bit 0 latches a status-change or wakeup assertion until software clears it.
// RULE10 - Powered-down wakeup pulses of about 1 ms are still captured.
// RULE11 - Status-change events are ignored from power-up start until power-up complete.
// RULE12 - Status-change capture is re-enabled when power-up complete is signalled.
// RULE13 - The card keeps its status-change line glitch free during power-down.
// RULE14 - Bits 1 and 2 set when their card detect input changes either way.
// RULE15 - Bit 3 sets when socket power-up for a 32-bit card finishes.
// RULE16 - A supply voltage the card does not support is never applied.
// RULE17 - Event bits 4 to 31 read as zero and ignore writes.
// RULE18 - Power-up complete is signalled 256 clock cycles after power-up begins.
// RULE19 - A removal interrupt with detect change enabled clears the mask register.
// RULE20 - Interrupt stays asserted while any enabled flag is set.
package sock_evt_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_EVENT   = 12'h000;
  localparam logic [11:0] OFS_MASK    = 12'h004;
  localparam logic [11:0] OFS_PRESENT = 12'h008;
  localparam logic [11:0] OFS_FORCE   = 12'h00C;
  localparam logic [11:0] OFS_CONTROL = 12'h010;

  // ----------------------------------------------------------------------
  // Event, mask, force and present-state bit positions
  // ----------------------------------------------------------------------
  localparam int BIT_STSCHG  = 0;
  localparam int BIT_DETECT1 = 1;
  localparam int BIT_DETECT2 = 2;
  localparam int BIT_POWER   = 3;
  localparam int EVENT_BITS  = 4;
  localparam int BIT_VCC_LO  = 4;
  localparam int BIT_VCC_HI  = 5;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_PWR_REQ   = 0;
  localparam int BIT_VSEL_LO   = 1;
  localparam int BIT_VSEL_HI   = 2;
  localparam int BIT_CARD_RST  = 3;
  localparam int CONTROL_BITS  = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] EVENT_RESET   = 4'h0;
  localparam logic [3:0] MASK_RESET    = 4'h0;
  localparam logic [3:0] CONTROL_RESET = 4'h8;

  // ----------------------------------------------------------------------
  // Supply selection codes and timing
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    VCC_OFF = 2'b00,
    VCC_5V0 = 2'b01,
    VCC_3V3 = 2'b10,
    VCC_XV  = 2'b11
  } vcc_sel_t;

  localparam int POWERUP_CYCLES = 256;

endpackage : sock_evt_pkg

// ### logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int         WIDTH = 1,
  parameter logic [0:0] INIT  = 1'b0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] stable_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs WIDTH of at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {WIDTH{INIT}};
      s2_q   <= {WIDTH{INIT}};
      s3_q   <= {WIDTH{INIT}};
    end else begin
      meta_q <= pin_in;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // A bit moves only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= {WIDTH{INIT}};
    end else begin
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
    end
  end

endmodule // pin_sync

// ### logic/power_seq.sv
// Socket power-up sequencer with fixed completion delay
`timescale 1ns/100ps
module power_seq #(
  parameter int CYCLES = 256
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic stop,
  output logic      busy_q,
  output logic      powered_q,
  output logic      done_q
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_q;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("power_seq needs CYCLES of at least 2");
  end

  // RULE18 fixed completion delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q  <= 1'b0;
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (stop) begin
        busy_q  <= 1'b0;
        count_q <= '0;
      end else if (start && !busy_q) begin
        busy_q  <= 1'b1;
        count_q <= CW'(1);
      end else if (busy_q) begin
        if (count_q == CW'(CYCLES - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        count_q <= count_q + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_q <= 1'b0;
    end else if (stop) begin
      powered_q <= 1'b0;
    end else if (done_q) begin
      powered_q <= 1'b1;
    end
  end

endmodule // power_seq

// ### logic/socket_status_event_flags.sv
// Socket status event flags with APB register slave and power control
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module socket_status_event_flags #(
  parameter int POWERUP_CYCLES = sock_evt_pkg::POWERUP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        card_stschg_in,
  input  wire logic [1:0]  card_detect_n_in,
  input  wire logic        card_supports_5v0,
  input  wire logic        card_supports_3v3,
  input  wire logic        card_supports_xv,
  output logic             card_reset_n_out,
  output logic             socket_power_en,
  output logic      [1:0]  socket_vcc_sel,
  output logic             status_change_irq_out
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (POWERUP_CYCLES < 2) begin : g_bad_cycles
    $error("POWERUP_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic       stschg_s;
  logic [1:0] detect_n_s;
  logic [2:0] vsup_s;

  pin_sync #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_sync_stschg (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (card_stschg_in),
    .stable_q (stschg_s)
  );

  // Detects idle high, so an empty socket wakes up without a false change
  pin_sync #(
    .WIDTH (2),
    .INIT  (1'b1)
  ) u_sync_detect (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (card_detect_n_in),
    .stable_q (detect_n_s)
  );

  pin_sync #(
    .WIDTH (3),
    .INIT  (1'b0)
  ) u_sync_vsup (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   ({card_supports_xv, card_supports_3v3, card_supports_5v0}),
    .stable_q (vsup_s)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit_event;
  logic hit_mask;
  logic hit_present;
  logic hit_force;
  logic hit_control;
  logic hit_any;

  assign hit_event   = (paddr == sock_evt_pkg::OFS_EVENT);
  assign hit_mask    = (paddr == sock_evt_pkg::OFS_MASK);
  assign hit_present = (paddr == sock_evt_pkg::OFS_PRESENT);
  assign hit_force   = (paddr == sock_evt_pkg::OFS_FORCE);
  assign hit_control = (paddr == sock_evt_pkg::OFS_CONTROL);
  assign hit_any     = hit_event | hit_mask | hit_present | hit_force | hit_control;

  // Zero wait states; strobe byte 0 carries every implemented bit
  assign wr_en   = psel & penable & pwrite & pstrb[0];
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ----------------------------------------------------------------------
  // Control register and card reset
  // ----------------------------------------------------------------------
  logic [sock_evt_pkg::CONTROL_BITS-1:0] control_q;
  logic                                  card_rst_prev_q;
  logic                                  card_rst_release;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= sock_evt_pkg::CONTROL_RESET;
    end else if (wr_en && hit_control) begin
      control_q <= pwdata[sock_evt_pkg::CONTROL_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_rst_prev_q <= 1'b1;
    end else begin
      card_rst_prev_q <= control_q[sock_evt_pkg::BIT_CARD_RST];
    end
  end

  assign card_rst_release = card_rst_prev_q & ~control_q[sock_evt_pkg::BIT_CARD_RST];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_reset_n_out <= 1'b0;
    end else begin
      card_reset_n_out <= ~control_q[sock_evt_pkg::BIT_CARD_RST];
    end
  end

  // ----------------------------------------------------------------------
  // Socket power
  // ----------------------------------------------------------------------
  logic                   pwr_req;
  sock_evt_pkg::vcc_sel_t vsel_req;
  logic                   vsel_ok;
  logic                   pwr_start;
  logic                   pwr_stop;
  logic                   pwr_busy;
  logic                   pwr_on;
  logic                   pwr_done;

  assign pwr_req  = control_q[sock_evt_pkg::BIT_PWR_REQ];
  assign vsel_req = sock_evt_pkg::vcc_sel_t'(
                      control_q[sock_evt_pkg::BIT_VSEL_HI:sock_evt_pkg::BIT_VSEL_LO]);

  // RULE16 refuse unsupported voltage
  always_comb begin
    unique case (vsel_req)
      sock_evt_pkg::VCC_OFF: vsel_ok = 1'b0;
      sock_evt_pkg::VCC_5V0: vsel_ok = vsup_s[0];
      sock_evt_pkg::VCC_3V3: vsel_ok = vsup_s[1];
      sock_evt_pkg::VCC_XV:  vsel_ok = vsup_s[2];
    endcase
  end

  assign pwr_start = pwr_req & vsel_ok & ~socket_power_en;
  assign pwr_stop  = ~pwr_req;

  power_seq #(
    .CYCLES (POWERUP_CYCLES)
  ) u_power_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (pwr_start),
    .stop      (pwr_stop),
    .busy_q    (pwr_busy),
    .powered_q (pwr_on),
    .done_q    (pwr_done)
  );

  // Supply held at the accepted code until software drops the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      socket_power_en <= 1'b0;
      socket_vcc_sel  <= sock_evt_pkg::VCC_OFF;
    end else if (pwr_stop) begin
      socket_power_en <= 1'b0;
      socket_vcc_sel  <= sock_evt_pkg::VCC_OFF;
    end else if (pwr_start) begin
      socket_power_en <= 1'b1;
      socket_vcc_sel  <= vsel_req;
    end
  end

  // ----------------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------------
  logic       stschg_prev_q;
  logic [1:0] detect_prev_q;
  logic       stschg_rise;
  logic [1:0] detect_chg;
  logic [1:0] detect_removed;
  logic       stschg_block;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stschg_prev_q <= 1'b0;
      detect_prev_q <= 2'b11;
    end else begin
      stschg_prev_q <= stschg_s;
      detect_prev_q <= detect_n_s;
    end
  end

  // RULE9 capture assertion edge only
  assign stschg_rise = stschg_s & ~stschg_prev_q;
  // RULE14 either-direction detect change
  assign detect_chg     = detect_n_s ^ detect_prev_q;
  assign detect_removed = detect_chg & detect_n_s;

  // RULE11 blind during power-up; RULE12 done clears the blind
  assign stschg_block = pwr_busy & ~pwr_done;

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  logic [sock_evt_pkg::EVENT_BITS-1:0] event_q;
  logic [sock_evt_pkg::EVENT_BITS-1:0] event_d;
  logic [sock_evt_pkg::EVENT_BITS-1:0] hw_set;
  logic [sock_evt_pkg::EVENT_BITS-1:0] sw_set;
  logic [sock_evt_pkg::EVENT_BITS-1:0] sw_clr;
  logic                                still_stschg;
  logic [1:0]                          still_detect;

  // RULE6 status still present at card reset release
  assign still_stschg = card_rst_release & stschg_s;
  assign still_detect = {2{card_rst_release}} & ~detect_n_s;

  // RULE10 synchronised level outlives any millisecond pulse
  always_comb begin
    hw_set = '0;
    hw_set[sock_evt_pkg::BIT_STSCHG]  = (stschg_rise | still_stschg) & ~stschg_block;
    hw_set[sock_evt_pkg::BIT_DETECT1] = detect_chg[0] | still_detect[0];
    hw_set[sock_evt_pkg::BIT_DETECT2] = detect_chg[1] | still_detect[1];
    // RULE15 power-up finished
    hw_set[sock_evt_pkg::BIT_POWER]   = pwr_done;
  end

  // RULE4 force register sets flags
  assign sw_set = (wr_en && hit_force) ? pwdata[sock_evt_pkg::EVENT_BITS-1:0] : '0;
  // RULE3 write one to clear
  assign sw_clr = (wr_en && hit_event) ? pwdata[sock_evt_pkg::EVENT_BITS-1:0] : '0;

  // RULE1 flags hold change only; set wins over clear
  assign event_d = (event_q & ~sw_clr) | hw_set | sw_set;

  // RULE5 bus reset clears all flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= sock_evt_pkg::EVENT_RESET;
    end else begin
      event_q <= event_d;
    end
  end

  // ----------------------------------------------------------------------
  // Mask register and removal handling
  // ----------------------------------------------------------------------
  logic [sock_evt_pkg::EVENT_BITS-1:0] mask_q;
  logic                                removal_irq;
  logic                                removal_hold_q;
  logic                                detect_flags_clear;

  assign removal_irq = |(detect_removed & mask_q[sock_evt_pkg::BIT_DETECT2:
                                                 sock_evt_pkg::BIT_DETECT1]);

  // RULE19 removal interrupt clears the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= sock_evt_pkg::MASK_RESET;
    end else if (removal_irq) begin
      mask_q <= sock_evt_pkg::MASK_RESET;
    end else if (wr_en && hit_mask) begin
      mask_q <= pwdata[sock_evt_pkg::EVENT_BITS-1:0];
    end
  end

  assign detect_flags_clear = ~event_d[sock_evt_pkg::BIT_DETECT1] &
                              ~event_d[sock_evt_pkg::BIT_DETECT2];

  // Keeps the removal interrupt alive after its mask bit is wiped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      removal_hold_q <= 1'b0;
    end else if (removal_irq) begin
      removal_hold_q <= 1'b1;
    end else if (detect_flags_clear) begin
      removal_hold_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  // RULE2 RULE7 RULE20 flags gated by mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_change_irq_out <= 1'b0;
    end else begin
      status_change_irq_out <= (|(event_q & mask_q)) | removal_hold_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata_d;

  // RULE17 upper bits read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_event) begin
      rdata_d[sock_evt_pkg::EVENT_BITS-1:0] = event_q;
    end else if (hit_mask) begin
      rdata_d[sock_evt_pkg::EVENT_BITS-1:0] = mask_q;
    end else if (hit_present) begin
      rdata_d[sock_evt_pkg::BIT_STSCHG]  = stschg_s;
      rdata_d[sock_evt_pkg::BIT_DETECT1] = detect_n_s[0];
      rdata_d[sock_evt_pkg::BIT_DETECT2] = detect_n_s[1];
      rdata_d[sock_evt_pkg::BIT_POWER]   = pwr_on;
      rdata_d[sock_evt_pkg::BIT_VCC_HI:sock_evt_pkg::BIT_VCC_LO] = socket_vcc_sel;
    end else if (hit_control) begin
      rdata_d[sock_evt_pkg::CONTROL_BITS-1:0] = control_q;
    end
  end

  // Registered on the setup cycle so data is steady in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Read enable kept for symmetry of decode; reads have no side effects
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule // socket_status_event_flags

// ### testbench/sock_evt_props.sv
// Assertion checker for the socket status event flag block
`timescale 1ns/100ps
module sock_evt_props #(
  parameter int POWERUP_CYCLES = 256
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        card_stschg_in,
  input wire logic [1:0]  card_detect_n_in,
  input wire logic        card_supports_5v0,
  input wire logic        card_supports_3v3,
  input wire logic        card_supports_xv,
  input wire logic        card_reset_n_out,
  input wire logic        socket_power_en,
  input wire logic [1:0]  socket_vcc_sel,
  input wire logic        status_change_irq_out
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc_wr;
  logic pwr_wr;
  assign acc_wr = psel && penable && pwrite;
  assign pwr_wr = acc_wr && paddr == sock_evt_pkg::OFS_CONTROL && pwdata[0];

  a_reserved_reads_zero: assert property (
    psel && penable && !pwrite && paddr == sock_evt_pkg::OFS_EVENT |-> prdata[31:4] == 28'h0)
    else $error("reserved event bits read nonzero");
  a_reset_irq_low: assert property (
    $rose(presetn) |-> !status_change_irq_out && prdata == 32'h0)
    else $error("irq or read data set after reset");
  a_vcc_5v0_legal: assert property (
    socket_power_en && socket_vcc_sel == sock_evt_pkg::VCC_5V0 |-> card_supports_5v0)
    else $error("unsupported 5V supply applied");
  a_vcc_3v3_legal: assert property (
    socket_power_en && socket_vcc_sel == sock_evt_pkg::VCC_3V3 |-> card_supports_3v3)
    else $error("unsupported 3.3V supply applied");
  a_vcc_xv_legal: assert property (
    socket_power_en && socket_vcc_sel == sock_evt_pkg::VCC_XV |-> card_supports_xv)
    else $error("unsupported X supply applied");
  a_power_on_request: assert property (
    $rose(socket_power_en) |-> $past(pwr_wr, 1) || $past(pwr_wr, 2) || $past(pwr_wr, 3))
    else $error("socket powered without request");
  a_irq_falls_write: assert property (
    $fell(status_change_irq_out) |-> $past(acc_wr, 1) || $past(acc_wr, 2))
    else $error("irq dropped without software write");
  a_irq_not_live: assert property (
    $rose(card_stschg_in) |-> !$rose(status_change_irq_out) ##1 !$rose(status_change_irq_out))
    else $error("irq follows live status pin");
endmodule // sock_evt_props

bind socket_status_event_flags sock_evt_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .card_stschg_in(card_stschg_in), .card_detect_n_in(card_detect_n_in),
  .card_supports_5v0(card_supports_5v0), .card_supports_3v3(card_supports_3v3),
  .card_supports_xv(card_supports_xv), .card_reset_n_out(card_reset_n_out),
  .socket_power_en(socket_power_en), .socket_vcc_sel(socket_vcc_sel),
  .status_change_irq_out(status_change_irq_out));

// ### testbench/card_model.sv
// Behavioural card as seen from the socket pins
`timescale 1ns/100ps
module card_model (
  input  wire logic       pclk,
  input  wire logic       inserted,
  input  wire logic       stschg_req,
  input  wire logic [2:0] supports,
  output logic            card_stschg_in,
  output logic      [1:0] card_detect_n_in,
  output logic            card_supports_5v0,
  output logic            card_supports_3v3,
  output logic            card_supports_xv
);
  logic       stschg_q   = 1'b0;
  logic [1:0] detect_n_q = 2'b11;
  // glitch free status
  // Registered so the status line stays clean even across removal
  always @(posedge pclk) begin
    stschg_q   <= inserted && stschg_req;
    detect_n_q <= {2{!inserted}};
  end
  assign card_stschg_in    = stschg_q;
  assign card_detect_n_in  = detect_n_q;
  // Empty socket: sense lines pulled low
  assign card_supports_5v0 = inserted && supports[0];
  assign card_supports_3v3 = inserted && supports[1];
  assign card_supports_xv  = inserted && supports[2];
endmodule // card_model

// ### testbench/testbench.sv
// Self-checking bench for the socket status event flag block
`timescale 1ns/100ps
module testbench;
  localparam logic [11:0] EVT = sock_evt_pkg::OFS_EVENT;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic        inserted   = 1'b0;
  logic        stschg_req = 1'b0;
  logic [2:0]  supports   = 3'h0;
  logic [3:0]  strb       = 4'hF;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic [1:0]  det_n;
  logic [1:0]  vcc;
  logic        pready, pslverr, rerr, stschg, s5, s3, sx, crst_n, pwr_en, irq;
  int          miscompares = 0;
  int          checks      = 0;
  int          cycles      = 0;
  int          n;

  always #2.5 pclk = ~pclk;

  socket_status_event_flags #(.POWERUP_CYCLES(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_stschg_in(stschg), .card_detect_n_in(det_n),
    .card_supports_5v0(s5), .card_supports_3v3(s3), .card_supports_xv(sx),
    .card_reset_n_out(crst_n), .socket_power_en(pwr_en), .socket_vcc_sel(vcc),
    .status_change_irq_out(irq));

  card_model card (
    .pclk(pclk), .inserted(inserted), .stschg_req(stschg_req), .supports(supports),
    .card_stschg_in(stschg), .card_detect_n_in(det_n), .card_supports_5v0(s5),
    .card_supports_3v3(s3), .card_supports_xv(sx));

  // ----------------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------------
  task automatic results;
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask

  task automatic ci(input logic exp);
    wt(3);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  task automatic pulse;
    stschg_req <= 1'b1;
    wt(8);
    stschg_req <= 1'b0;
    wt(10);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    wt(5);
    presetn <= 1'b1;
    rc("event", EVT, 32'h0);
    wr(sock_evt_pkg::OFS_FORCE, 32'hFFFF_FFFF);
    rc("force", EVT, 32'hF);
    strb <= 4'h0;
    wr(EVT, 32'hF);
    strb <= 4'hF;
    rc("nostrb", EVT, 32'hF);
    wr(EVT, 32'h5);
    rc("w1c", EVT, 32'hA);
    wr(EVT, 32'h0);
    rc("w0", EVT, 32'hA);
    wr(EVT, 32'hFFFF_FFFF);
    rc("clear", EVT, 32'h0);
    wr(sock_evt_pkg::OFS_FORCE, 32'h2);
    ci(1'b0);
    wr(sock_evt_pkg::OFS_MASK, 32'h2);
    ci(1'b1);
    wr(EVT, 32'h2);
    ci(1'b0);
    wr(sock_evt_pkg::OFS_MASK, 32'h0);
    inserted <= 1'b1;
    wt(10);
    rc("insert", EVT, 32'h6);
    rc("present", sock_evt_pkg::OFS_PRESENT, 32'h0);
    wr(EVT, 32'h6);
    wr(sock_evt_pkg::OFS_MASK, 32'h6);
    inserted <= 1'b0;
    wt(10);
    ci(1'b1);
    rc("automask", sock_evt_pkg::OFS_MASK, 32'h0);
    rc("remove", EVT, 32'h6);
    wr(EVT, 32'h6);
    ci(1'b0);
    inserted <= 1'b1;
    wt(10);
    wr(EVT, 32'hF);
    pulse();
    rc("wakeup", EVT, 32'h1);
    stschg_req <= 1'b1;
    wt(10);
    wr(EVT, 32'hF);
    wr(sock_evt_pkg::OFS_CONTROL, 32'h0);
    wt(10);
    rc("crst", EVT, 32'h7);
    stschg_req <= 1'b0;
    supports   <= 3'b010;
    wt(10);
    wr(EVT, 32'hF);
    wr(sock_evt_pkg::OFS_MASK, 32'h8);
    wr(sock_evt_pkg::OFS_CONTROL, 32'h5);
    stschg_req <= 1'b1;
    wt(2);
    ci(1'b0);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("pwrtime", n, 32'h6);
    rc("powered", sock_evt_pkg::OFS_PRESENT, 32'h29);
    stschg_req <= 1'b0;
    rc("pwrdone", EVT, 32'h8);
    wr(sock_evt_pkg::OFS_MASK, 32'h0);
    wr(EVT, 32'hF);
    pulse();
    rc("reenable", EVT, 32'h1);
    wr(sock_evt_pkg::OFS_CONTROL, 32'h0);
    wt(10);
    supports <= 3'b001;
    wr(sock_evt_pkg::OFS_CONTROL, 32'h7);
    wt(20);
    rc("novcc", sock_evt_pkg::OFS_PRESENT, 32'h0);
    wr(sock_evt_pkg::OFS_CONTROL, 32'h3);
    wt(20);
    rc("vcc5", sock_evt_pkg::OFS_PRESENT, 32'h18);
    wr(sock_evt_pkg::OFS_CONTROL, 32'h0);
    xfer(1'b0, 12'h014, 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    chk("unmapped", rdat, 32'h0);
    inserted <= 1'b0;
    wt(10);
    wr(sock_evt_pkg::OFS_FORCE, 32'hF);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    rc("rereset", EVT, 32'h0);
    results();
  end
endmodule // testbench
